// File: verilog/wstc_top.sv
// Overview of operation
// - after power-on reset the device enters the configuration state by itself
// - host command moves a configured device from configuration to normal
// - sleep or standby commands are accepted from normal or wake
// - level input is a wake only after staying high the minimum time
// - a rising edge on the edge input is a wake event
// - wake: standby to config, sleep to wake, safe shutdown to config
// - low level and falling edge cause no transition
// - wake during normal-to-sleep goes to wake and raises interrupt
// - wake during normal-to-standby goes to config and asserts reset output
// - low-power commands are obeyed while the edge input is high
// - minimum level wake duration is 40 microseconds
`timescale 1ns/1ns
`default_nettype none

module wstc_top
   import wstc_pkg::*;
(
   input  wire logic           i_clk_sys,
   input  wire logic           i_rst_n,
   input  wire logic           i_level_trigger_input,
   input  wire logic           i_edge_trigger_input,
   input  wire logic           i_cmd_valid,
   input  wire logic [2:0]     i_cmd_code,
   input  wire logic           i_config_done,
   input  wire logic           i_safe_shutdown,
   output logic [2:0]          o_state,
   output logic                o_reset_output_n,
   output logic                o_interrupt
);

   // ***************************************************************
   // wake input conditioning
   // ***************************************************************

   wstc_pins_type pins_raw;
   wstc_pins_type pins_sync;
   logic          wake;

   assign pins_raw.level_trigger_input = i_level_trigger_input;
   assign pins_raw.edge_trigger_input  = i_edge_trigger_input;

   wstc_sync u_sync
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_pins    (pins_raw),
      .o_pins    (pins_sync)
   );

   wstc_qual u_qual
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_level   (pins_sync.level_trigger_input),
      .i_edge    (pins_sync.edge_trigger_input),
      .o_wake    (wake)
   );

   // ***************************************************************
   // state machine
   // ***************************************************************

   wstc_cmd_type           cmd;
   wstc_state_type         state;
   wstc_state_type         next_state;
   logic [`WSTC_TCNT_W-1:0] tcnt;
   logic [`WSTC_TCNT_W-1:0] next_tcnt;
   logic [`WSTC_TCNT_W-1:0] rcnt;
   logic [`WSTC_TCNT_W-1:0] next_rcnt;
   logic                   next_reset_n;
   logic                   next_interrupt;

   localparam logic [`WSTC_TCNT_W-1:0] TRANS_LAST =
      `WSTC_TCNT_W'(`WSTC_TRANS_CYC - 1);
   localparam logic [`WSTC_TCNT_W-1:0] RST_LEN =
      `WSTC_TCNT_W'(`WSTC_RST_CYC);

   assign cmd.valid = i_cmd_valid;
   assign cmd.code  = i_cmd_code;

   function automatic logic is_cmd(input wstc_cmd_type c,
                                   input logic [2:0] code);
      is_cmd = c.valid && (c.code == code);
   endfunction

   always_comb
   begin
      next_state     = state;
      next_tcnt      = '0;
      next_rcnt      = (rcnt != '0) ? rcnt - `WSTC_TCNT_W'(1) : rcnt;
      next_interrupt = 1'b0;
      case (state)
         WSTC_ST_INIT:
         begin
            if (i_config_done && is_cmd(cmd, `WSTC_CMD_NORMAL))
               next_state = WSTC_ST_NORMAL;
         end
         WSTC_ST_NORMAL, WSTC_ST_WAKE:
         begin
            // edge input level plays no part here
            if (is_cmd(cmd, `WSTC_CMD_SLEEP))
               next_state = (state == WSTC_ST_NORMAL) ?
                            WSTC_ST_TO_SLEEP : WSTC_ST_SLEEP;
            else if (is_cmd(cmd, `WSTC_CMD_STANDBY))
               next_state = (state == WSTC_ST_NORMAL) ?
                            WSTC_ST_TO_STANDBY : WSTC_ST_STANDBY;
         end
         WSTC_ST_TO_SLEEP:
         begin
            next_tcnt = tcnt + `WSTC_TCNT_W'(1);
            if (wake)
            begin
               next_state     = WSTC_ST_WAKE;
               next_interrupt = 1'b1;
            end
            else if (tcnt == TRANS_LAST)
               next_state = WSTC_ST_SLEEP;
         end
         WSTC_ST_TO_STANDBY:
         begin
            next_tcnt = tcnt + `WSTC_TCNT_W'(1);
            if (wake)
            begin
               next_state = WSTC_ST_INIT;
               next_rcnt  = RST_LEN;
            end
            else if (tcnt == TRANS_LAST)
               next_state = WSTC_ST_STANDBY;
         end
         WSTC_ST_SLEEP:
         begin
            if (wake)
               next_state = WSTC_ST_WAKE;
         end
         WSTC_ST_STANDBY, WSTC_ST_SAFE:
         begin
            if (wake)
               next_state = WSTC_ST_INIT;
         end
         default:
            next_state = WSTC_ST_INIT;
      endcase
      // safe shutdown request overrides, but a wake still leaves it
      if (i_safe_shutdown && state != WSTC_ST_SAFE)
      begin
         next_state     = WSTC_ST_SAFE;
         next_interrupt = 1'b0;
      end
      next_reset_n = (next_rcnt == '0);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state            <= WSTC_ST_INIT;
         tcnt             <= '0;
         rcnt             <= '0;
         o_reset_output_n <= 1'b0;
         o_interrupt      <= 1'b0;
      end
      else
      begin
         state            <= next_state;
         tcnt             <= next_tcnt;
         rcnt             <= next_rcnt;
         o_reset_output_n <= next_reset_n;
         o_interrupt      <= next_interrupt;
      end
   end

   assign o_state = state;

endmodule

`default_nettype wire

// File: verilog/wstc_params.svh
`ifndef WSTC_PARAMS_SVH
`define WSTC_PARAMS_SVH

// clock and wake timing
`define WSTC_CLK_MHZ        125
`define WSTC_WAKE_MIN_US    40
`define WSTC_WAKE_MIN_CYC   (`WSTC_WAKE_MIN_US * `WSTC_CLK_MHZ)
`define WSTC_ENA_HIGH_US    20
`define WSTC_CNT_W          13
// length of the transition phase into a low-power state, cycles
`define WSTC_TRANS_CYC      16
`define WSTC_TCNT_W         5
// cycles for which the reset output is held low
`define WSTC_RST_CYC        16

// command codes
`define WSTC_CMD_NONE       3'h0
`define WSTC_CMD_NORMAL     3'h1
`define WSTC_CMD_SLEEP      3'h2
`define WSTC_CMD_STANDBY    3'h3

`endif

// File: verilog/wstc_pkg.sv
`include "wstc_params.svh"

package wstc_pkg;

   typedef enum logic [2:0]
   {
      WSTC_ST_INIT       = 3'h0,
      WSTC_ST_NORMAL     = 3'h1,
      WSTC_ST_TO_SLEEP   = 3'h2,
      WSTC_ST_TO_STANDBY = 3'h3,
      WSTC_ST_SLEEP      = 3'h4,
      WSTC_ST_STANDBY    = 3'h5,
      WSTC_ST_WAKE       = 3'h6,
      WSTC_ST_SAFE       = 3'h7
   } wstc_state_type;

   typedef struct packed
   {
      logic       valid;
      logic [2:0] code;
   } wstc_cmd_type;

   typedef struct packed
   {
      logic level_trigger_input;
      logic edge_trigger_input;
   } wstc_pins_type;

endpackage

// File: verilog/wstc_sync.sv
`timescale 1ns/1ns
`default_nettype none

module wstc_sync
   import wstc_pkg::*;
(
   input  wire logic          i_clk_sys,
   input  wire logic          i_rst_n,
   input  wire wstc_pins_type i_pins,
   output var  wstc_pins_type o_pins
);

   wstc_pins_type stage1;
   wstc_pins_type stage2;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         stage1 <= '0;
         stage2 <= '0;
      end
      else
      begin
         stage1 <= i_pins;
         stage2 <= stage1;
      end
   end

   assign o_pins = stage2;

endmodule

`default_nettype wire

// File: verilog/wstc_qual.sv
`timescale 1ns/1ns
`default_nettype none

module wstc_qual
   import wstc_pkg::*;
(
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   input  wire logic i_level,
   input  wire logic i_edge,
   output logic      o_wake
);

   logic [`WSTC_CNT_W-1:0] cnt;
   logic [`WSTC_CNT_W-1:0] next_cnt;
   logic                   edge_dly;
   logic                   next_edge_dly;
   logic                   fired;
   logic                   next_fired;
   logic                   next_wake;

   localparam logic [`WSTC_CNT_W-1:0] WAKE_MIN =
      `WSTC_CNT_W'(`WSTC_WAKE_MIN_CYC);

   always_comb
   begin
      next_cnt      = cnt;
      next_fired    = fired;
      next_wake     = 1'b0;
      next_edge_dly = i_edge;
      // a low level only rearms the qualifier
      if (!i_level)
      begin
         next_cnt   = '0;
         next_fired = 1'b0;
      end
      else if (!fired)
      begin
         if (cnt == WAKE_MIN - `WSTC_CNT_W'(1))
         begin
            next_wake  = 1'b1;
            next_fired = 1'b1;
         end
         else
            next_cnt = cnt + `WSTC_CNT_W'(1);
      end
      // rising edge only; falling edge ignored
      if (i_edge && !edge_dly)
         next_wake = 1'b1;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt      <= '0;
         fired    <= 1'b0;
         edge_dly <= 1'b0;
         o_wake   <= 1'b0;
      end
      else
      begin
         cnt      <= next_cnt;
         fired    <= next_fired;
         edge_dly <= next_edge_dly;
         o_wake   <= next_wake;
      end
   end

endmodule

`default_nettype wire

// File: dv/wstc_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module wstc_assertions
(
   input wire logic       i_clk_sys,
   input wire logic       i_rst_n,
   input wire logic       i_cmd_valid,
   input wire logic [2:0] i_cmd_code,
   input wire logic       i_config_done,
   input wire logic       i_safe_shutdown,
   input wire logic [2:0] o_state,
   input wire logic       o_reset_output_n,
   input wire logic       o_interrupt
);
   // ****
   // state machine checks
   // ****
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   logic cmd_ok;
   // safe shutdown request outranks any command
   assign cmd_ok = i_cmd_valid && !i_safe_shutdown;
   sequence s_rst_low;
      !o_reset_output_n [*8];
   endsequence
   a_por_init: assert property ($rose(i_rst_n) |-> o_state == 3'h0)
      else $error("state not init after reset");
   a_normal_cmd: assert property (cmd_ok && i_cmd_code == 3'h1 &&
      i_config_done && o_state == 3'h0 |=> o_state == 3'h1)
      else $error("normal command not taken");
   a_sleep_cmd: assert property (cmd_ok && i_cmd_code == 3'h2 &&
      o_state == 3'h1 |=> o_state == 3'h2)
      else $error("sleep command not taken");
   a_wake_irq: assert property ($past(o_state) == 3'h2 &&
      o_state == 3'h6 |-> o_interrupt)
      else $error("no interrupt on wake in transition");
   a_irq_pulse: assert property (o_interrupt |=> !o_interrupt)
      else $error("interrupt longer than one cycle");
   a_rst_len: assert property ($fell(o_reset_output_n) |->
      s_rst_low ##1 s_rst_low ##1 o_reset_output_n)
      else $error("reset output not 16 cycles");
   a_rst_init: assert property ($fell(o_reset_output_n) |->
      o_state == 3'h0) else $error("reset output outside init");
   a_sleep_exit: assert property ($past(o_state) == 3'h4 &&
      o_state != 3'h4 |-> o_state inside {3'h6, 3'h7})
      else $error("sleep left to wrong state");
   a_stby_exit: assert property ($past(o_state) == 3'h5 &&
      o_state != 3'h5 |-> o_state inside {3'h0, 3'h7})
      else $error("standby left to wrong state");
endmodule
`default_nettype wire

// File: dv/wstc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module wstc_host_model
(
   input  wire logic  i_clk_sys,
   output logic       o_cmd_valid,
   output logic [2:0] o_cmd_code
);
   initial
   begin
      o_cmd_valid = 1'h0;
      o_cmd_code  = 3'h0;
   end
   // one-cycle strobe launched on the falling edge
   task automatic send(input logic [2:0] code);
      @(negedge i_clk_sys);
      o_cmd_valid = 1'h1;
      o_cmd_code  = code;
      @(negedge i_clk_sys);
      o_cmd_valid = 1'h0;
      o_cmd_code  = ~code;
   endtask
endmodule
`default_nettype wire

// File: dv/wstc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module wstc_top_tb;
   logic i_clk_sys, i_rst_n, i_level_trigger_input, i_edge_trigger_input;
   logic i_cmd_valid, i_config_done, i_safe_shutdown;
   logic [2:0] i_cmd_code, o_state;
   logic o_reset_output_n, o_interrupt;
   logic [15:0] irq_cnt, lo_cnt;
   int errors, cmp_count;
   wstc_top u_wstc_top (.i_clk_sys, .i_rst_n, .i_level_trigger_input,
      .i_edge_trigger_input, .i_cmd_valid, .i_cmd_code, .i_config_done,
      .i_safe_shutdown, .o_state, .o_reset_output_n, .o_interrupt);
   wstc_host_model u_wstc_host_model (.i_clk_sys,
      .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code));
   initial
   begin
      i_clk_sys = 1'h0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys)
   begin
      irq_cnt <= irq_cnt + {15'h0, o_interrupt};
      lo_cnt  <= lo_cnt + {15'h0, i_rst_n & ~o_reset_output_n};
   end
   // ****
   // helpers
   // ****
   task chk(input logic [15:0] seen, exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task wait_st(input logic [2:0] exp, input int lim);
      int k;
      for (k = 0; k < lim && o_state !== exp; k++)
         @(negedge i_clk_sys);
      chk(16'(o_state), 16'(exp), "state");
      if (o_state !== exp)
         wrap_up();
   endtask
   task reset_dut;
      @(negedge i_clk_sys);
      {i_rst_n, i_level_trigger_input, i_edge_trigger_input} = 3'h0;
      {i_config_done, i_safe_shutdown} = 2'h0;
      cyc(8);
      i_rst_n = 1'h1;
      // let the first edge raise the reset output before counting lows
      cyc(1);
      irq_cnt = 16'h0;
      lo_cnt  = 16'h0;
   endtask
   task go_normal;
      reset_dut();
      i_config_done = 1'h1;
      u_wstc_host_model.send(3'h1);
      wait_st(3'h1, 4);
   endtask
   // ****
   // scenarios
   // ****
   task t_por;
      reset_dut();
      cyc(2);
      chk(16'(o_state), 16'h0, "state");
      chk(16'(o_reset_output_n), 16'h1, "reset out");
      u_wstc_host_model.send(3'h1);
      cyc(3);
      chk(16'(o_state), 16'h0, "state");
   endtask
   task t_edge_sleep;
      go_normal();
      i_edge_trigger_input = 1'h1;
      cyc(10);
      u_wstc_host_model.send(3'h2);
      wait_st(3'h2, 3);
      wait_st(3'h4, 20);
      cyc(2500);
      i_edge_trigger_input = 1'h0;
      cyc(10);
      chk(16'(o_state), 16'h4, "state");
      i_edge_trigger_input = 1'h1;
      wait_st(3'h6, 8);
      cyc(2500);
   endtask
   task t_phase(input logic [2:0] cmd, exp);
      go_normal();
      u_wstc_host_model.send(cmd);
      cyc(3);
      i_edge_trigger_input = 1'h1;
      wait_st(exp, 10);
      cyc(2500);
      chk(irq_cnt, {15'h0, cmd == 3'h2}, "irq count");
      chk(lo_cnt, cmd == 3'h3 ? 16'h10 : 16'h0, "reset low");
   endtask
   task t_level_safe;
      go_normal();
      u_wstc_host_model.send(3'h3);
      wait_st(3'h5, 20);
      i_level_trigger_input = 1'h1;
      cyc(4990);
      chk(16'(o_state), 16'h5, "state");
      wait_st(3'h0, 30);
      i_level_trigger_input = 1'h0;
      i_safe_shutdown = 1'h1;
      wait_st(3'h7, 4);
      i_safe_shutdown = 1'h0;
      cyc(5);
      i_edge_trigger_input = 1'h1;
      wait_st(3'h0, 8);
      cyc(2500);
   endtask
   task wrap_up;
      if (errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      errors    = 0;
      cmp_count = 0;
      t_por();
      t_edge_sleep();
      t_phase(3'h2, 3'h6);
      t_phase(3'h3, 3'h0);
      t_level_safe();
      wrap_up();
   end
endmodule
bind wstc_top wstc_assertions u_wstc_assertions (.i_clk_sys, .i_rst_n,
   .i_cmd_valid, .i_cmd_code, .i_config_done, .i_safe_shutdown, .o_state,
   .o_reset_output_n, .o_interrupt);
`default_nettype wire
